/* core/serial_link_phy_config.sv */
// Purpose: Link PHY and shell configuration registers, sideband pins, DMA requests.
// Assumes: 10 MHz clk, synchronous active-low nrst, AXI4-Lite register access.
// Notes: Uplink pins are asynchronous and pass two flip-flops before use.
// Functional notes
// - Word0 bit 31 powers down upstream, downstream and PLL; resets to 0.
// - Word0 bit 29 powers down serializer and output driver; resets to 0.
// - Word0 bit 28 powers down only the upstream receive path; resets to 0.
// - Word1 bits 19..14 give six-bit drive current, reset zero.
// - Word0 bits 26..24 give N; current reduced after N equal bits.
// - Word1 bits 13..8 set pre-emphasis current; zero turns driver off.
// - Word0 bits 11..8 select the upstream sampling point.
// - Word1 bits 23..20 set charge pump current, reset 1000.
// - Each of sixteen buffers raises its own DMA request, numbers 160..175.
// - Word1 bit 31 selects data mode when 1 (reset), pixel when 0.
// - Word1 bit 29 enables the PHY core clock; resets to 1.
// - Word3 bit 23 picks two-bit or one-bit uplink width, bit 21 the downlink width while no downlink clock runs.
// - Word3 bit 18 routes the shell to an external PHY via pins.
// - Word3 bit 22 qualifies uplink data by data bit 1 or valid.
// - Word3 bits 20..19 pick counter, trigger or no downlink clock.
// - After reset the downlink runs over the pixel channel.
// - A pin is general purpose unless both its function bits and Word3 bit 18 are set.
// - A read-only word reports the controller version.
// - Active buffers request DMA; read data goes to matching index or drops.
`default_nettype none
`include "serial_link_map.svh"
module serial_link_phy_config
    import serial_link_pkg::*;
#(
    parameter int NUM_BUF = 16,
    parameter logic [31:0] VERSION = `VERSION_VALUE // Arbitrary value.
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // AXI4-Lite slave
    input wire logic [15:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [15:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // PHY controls
    output phy_ctrl_t phyCtrl,
    // Sideband toward the shell
    input wire logic upValidIn,
    input wire logic [1:0] downDataIn,
    input wire logic downTrigger,
    output up_word_t upWord,
    // Sideband port pins
    input wire logic [7:0] pinIn,
    input wire logic [7:0] gpioOut,
    input wire logic [7:0] gpioOe,
    output logic [7:0] pinOut,
    output logic [7:0] pinOe,
    // Transaction buffers
    input wire logic [NUM_BUF-1:0] bufActive,
    input wire logic [NUM_BUF*8-1:0] bufIndex,
    input wire logic rxValid,
    input wire logic [7:0] rxIndex,
    output logic [NUM_BUF-1:0] dmaReq,
    output logic [NUM_BUF-1:0] rxStore,
    output logic rxDiscard
);

    // Register file and bus slave.
    logic [31:0] word0, word1, word3, portFunc;
    logic [31:0] next_word0, next_word1, next_word3, next_portFunc;
    logic [15:0] wAddr, next_wAddr;
    logic [31:0] wData, next_wData;
    logic [3:0] wStrb, next_wStrb;
    logic haveAddr, haveData, next_haveAddr, next_haveData;
    logic next_bvalid, next_arready, next_awready, next_wready;
    logic [1:0] next_bresp, next_rresp;
    logic next_rvalid;
    logic [31:0] next_rdata, mask;
    logic wrFire;

    always_comb begin
        next_word0 = word0;
        next_word1 = word1;
        next_word3 = word3;
        next_portFunc = portFunc;
        next_wAddr = wAddr;
        next_wData = wData;
        next_wStrb = wStrb;
        next_haveAddr = haveAddr;
        next_haveData = haveData;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        mask = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};
        wrFire = haveAddr && haveData && !bvalid;
        // Address and data are latched independently, in either order.
        if (awvalid && awready) begin
            next_wAddr = awaddr;
            next_haveAddr = 1'b1;
        end
        if (wvalid && wready) begin
            next_wData = wdata;
            next_wStrb = wstrb;
            next_haveData = 1'b1;
        end
        if (wrFire) begin
            next_haveAddr = 1'b0;
            next_haveData = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = `RESP_OKAY;
            case (wAddr)
                `OFF_PHY_WORD0: next_word0 = (word0 & ~mask) | (wData & mask);
                `OFF_PHY_WORD1: next_word1 = (word1 & ~mask) | (wData & mask);
                `OFF_SHELL_WORD3: next_word3 = (word3 & ~mask) | (wData & mask);
                `OFF_PORT_FUNC: next_portFunc = (portFunc & ~mask) | (wData & mask);
                `OFF_VERSION: next_bresp = `RESP_OKAY;
                default: next_bresp = `RESP_SLVERR;
            endcase
        end else if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        next_awready = !next_haveAddr;
        next_wready = !next_haveData;
        next_arready = !rvalid && !arready;
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp = `RESP_OKAY;
            case (araddr)
                `OFF_PHY_WORD0: next_rdata = word0;
                `OFF_PHY_WORD1: next_rdata = word1;
                `OFF_SHELL_WORD3: next_rdata = word3;
                `OFF_PORT_FUNC: next_rdata = {16'h0000, portFunc[15:0]};
                `OFF_VERSION: next_rdata = VERSION;
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = `RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            word0 <= `RST_PHY_WORD0;
            word1 <= `RST_PHY_WORD1;
            word3 <= `RST_SHELL_WORD3;
            portFunc <= `RST_PORT_FUNC;
            wAddr <= 16'h0000;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
            haveAddr <= 1'b0;
            haveData <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else begin
            word0 <= next_word0;
            word1 <= next_word1;
            word3 <= next_word3;
            portFunc <= next_portFunc;
            wAddr <= next_wAddr;
            wData <= next_wData;
            wStrb <= next_wStrb;
            haveAddr <= next_haveAddr;
            haveData <= next_haveData;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // PHY control outputs, one register stage behind the configuration words.
    phy_ctrl_t next_phyCtrl;

    always_comb begin
        next_phyCtrl.pdAll = word0[`W0_PD_ALL];
        next_phyCtrl.pdSer = word0[`W0_PD_SER];
        next_phyCtrl.pdUp = word0[`W0_PD_UP];
        next_phyCtrl.preEmphN = word0[`W0_PRE_N_HI:`W0_PRE_N_LO];
        next_phyCtrl.samplePoint = word0[`W0_SAMPLE_HI:`W0_SAMPLE_LO];
        next_phyCtrl.chargePump = word1[`W1_PUMP_HI:`W1_PUMP_LO];
        next_phyCtrl.driveCurrent = word1[`W1_DRIVE_HI:`W1_DRIVE_LO];
        next_phyCtrl.preEmphCurrent = word1[`W1_PREEMPH_HI:`W1_PREEMPH_LO];
        // A zero pre-emphasis code also shuts the output driver off.
        next_phyCtrl.driverOn = (word1[`W1_PREEMPH_HI:`W1_PREEMPH_LO] != 6'h00) &&
            !word0[`W0_PD_SER] && !word0[`W0_PD_ALL];
        next_phyCtrl.dataMode = word1[`W1_DATA_MODE];
        next_phyCtrl.coreClkEn = word1[`W1_CORE_CLK];
        // With the routing bit clear the downlink stays on the pixel channel.
        next_phyCtrl.extPhy = word3[`W3_EXT_PHY];
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            phyCtrl <= '0;
        end else begin
            phyCtrl <= next_phyCtrl;
        end
    end

    // Uplink: pins 0..2 carry clock and two data bits, synchronised here.
    logic [3:0] sync1, sync2, next_sync1, next_sync2;
    logic upClkPrev, next_upClkPrev;
    up_word_t next_upWord;
    logic [7:0] linkSel;

    assign linkSel = portFunc[7:0] & portFunc[15:8] & {8{word3[`W3_EXT_PHY]}};

    always_comb begin
        next_sync1 = {upValidIn, pinIn[2:0]};
        next_sync2 = sync1;
        next_upClkPrev = sync2[0];
        next_upWord.strobe = 1'b0;
        next_upWord.data = upWord.data;
        if (linkSel[0] && sync2[0] && !upClkPrev) begin
            // Qualify by data bit 1 or by the separate valid line.
            next_upWord.strobe = word3[`W3_UP_QUAL] ? sync2[2] : sync2[3];
            next_upWord.data = word3[`W3_UP_WIDE] ? sync2[2:1] : {1'b0, sync2[1]};
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            upClkPrev <= 1'b0;
            upWord <= '0;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            upClkPrev <= next_upClkPrev;
            upWord <= next_upWord;
        end
    end

    // Downlink sideband clock generation.
    logic [7:0] genCnt, next_genCnt, halfCycle;
    logic genClk, next_genClk;

    always_comb begin
        // Odd cycle times round both phases down; a zero setting still toggles.
        halfCycle = {1'b0, word3[`W3_CYCLE_HI:`W3_CYCLE_LO+1]};
        if (halfCycle == 8'h00) begin
            halfCycle = 8'h01;
        end
        next_genCnt = 8'h00;
        next_genClk = 1'b0;
        case (word3[`W3_GEN_HI:`W3_GEN_LO])
            `GEN_COUNTER: begin
                next_genClk = genClk;
                next_genCnt = genCnt + 8'h01;
                if (genCnt + 8'h01 >= halfCycle) begin
                    next_genCnt = 8'h00;
                    next_genClk = !genClk;
                end
            end
            `GEN_TRIGGER: next_genClk = downTrigger ? !genClk : genClk;
            default: next_genClk = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            genCnt <= 8'h00;
            genClk <= 1'b0;
        end else begin
            genCnt <= next_genCnt;
            genClk <= next_genClk;
        end
    end

    // Pin multiplexing between port logic and link functions.
    logic [7:0] linkOut, linkOe, next_pinOut, next_pinOe;
    logic genOn;

    always_comb begin
        genOn = (word3[`W3_GEN_HI:`W3_GEN_LO] == `GEN_COUNTER) ||
            (word3[`W3_GEN_HI:`W3_GEN_LO] == `GEN_TRIGGER);
        linkOut = 8'h00;
        linkOe = 8'hE0;
        linkOut[5] = downDataIn[0];
        linkOut[6] = genOn ? genClk : (word3[`W3_DOWN_WIDE] & downDataIn[1]);
        linkOut[7] = genClk;
        for (int i = 0; i < 8; i++) begin
            next_pinOut[i] = linkSel[i] ? linkOut[i] : gpioOut[i];
            next_pinOe[i] = linkSel[i] ? linkOe[i] : gpioOe[i];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pinOut <= 8'h00;
            pinOe <= 8'h00;
        end else begin
            pinOut <= next_pinOut;
            pinOe <= next_pinOe;
        end
    end

    // Transaction buffers: DMA requests and read-data steering.
    logic [NUM_BUF-1:0] hit, next_rxStore;
    logic next_rxDiscard;

    genvar g;
    generate
        for (g = 0; g < NUM_BUF; g++) begin : g_buf
            assign hit[g] = bufActive[g] && (bufIndex[g*8 +: 8] == rxIndex);
        end
    endgenerate

    always_comb begin
        next_rxStore = '0;
        // The lowest matching buffer takes the data when indices collide.
        for (int i = NUM_BUF - 1; i >= 0; i--) begin
            if (rxValid && hit[i]) begin
                next_rxStore = '0;
                next_rxStore[i] = 1'b1;
            end
        end
        next_rxDiscard = rxValid && (hit == '0);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            dmaReq <= '0;
            rxStore <= '0;
            rxDiscard <= 1'b0;
        end else begin
            dmaReq <= bufActive;
            rxStore <= next_rxStore;
            rxDiscard <= next_rxDiscard;
        end
    end

    // Checks.
    chk_pd_all: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) |-> phyCtrl.pdAll == $past(word0[`W0_PD_ALL]))
        else $error("Global power down does not follow word0 bit 31.");
    chk_pd_ser: assert property (@(posedge clk) disable iff (!nrst)
        phyCtrl.pdSer |-> !phyCtrl.driverOn)
        else $error("Driver on while serializer powered down.");
    chk_pd_up: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) |-> phyCtrl.pdUp == $past(word0[`W0_PD_UP]))
        else $error("Upstream power down mismatch.");
    chk_driver_off: assert property (@(posedge clk) disable iff (!nrst)
        phyCtrl.preEmphCurrent == 6'h00 |-> !phyCtrl.driverOn)
        else $error("Driver on with zero pre-emphasis code.");
    chk_reset_defaults: assert property (@(posedge clk)
        !nrst |=> word1 == `RST_PHY_WORD1 && word3 == `RST_SHELL_WORD3 && word0 == 32'h0)
        else $error("Configuration words not at reset defaults.");
    chk_write_back: assert property (@(posedge clk) disable iff (!nrst)
        wrFire && wAddr == `OFF_PHY_WORD0 && wStrb == 4'hF |=> word0 == $past(wData))
        else $error("Word0 write not stored.");
    chk_version_read: assert property (@(posedge clk) disable iff (!nrst)
        arvalid && arready && araddr == `OFF_VERSION |=> rvalid && rdata == VERSION)
        else $error("Version read returned wrong data.");
    chk_dma_follow: assert property (@(posedge clk) disable iff (!nrst)
        $past(nrst) |-> dmaReq == $past(bufActive))
        else $error("DMA request does not follow active buffers.");
    chk_rx_discard: assert property (@(posedge clk) disable iff (!nrst)
        rxValid && hit == '0 |=> rxDiscard && rxStore == '0)
        else $error("Unmatched read data not discarded.");
    chk_gen_off: assert property (@(posedge clk) disable iff (!nrst)
        !genOn [*2] |-> !genClk)
        else $error("Downlink clock runs while generation disabled.");
    chk_gpio_pass: assert property (@(posedge clk) disable iff (!nrst)
        linkSel == 8'h00 |=> pinOut == $past(gpioOut) && pinOe == $past(gpioOe))
        else $error("Pins not in general-purpose mode.");

endmodule : serial_link_phy_config
`default_nettype wire

/* inc/serial_link_map.svh */
// Purpose: Register offsets, field positions, reset values, mode, DMA and response codes.
// Assumes: AXI4-Lite byte addresses, one aligned 32-bit word per register.
// Notes: Definitions only.
`ifndef SERIAL_LINK_MAP_SVH
`define SERIAL_LINK_MAP_SVH

`define OFF_PHY_WORD0 16'h7300
`define OFF_PHY_WORD1 16'h7304
`define OFF_SHELL_WORD3 16'h730C
`define OFF_PORT_FUNC 16'h7310
`define OFF_VERSION 16'h7320

`define RST_PHY_WORD0 32'h0000_0000
`define RST_PHY_WORD1 32'hA080_0000
`define RST_SHELL_WORD3 32'h00A0_000B
`define RST_PORT_FUNC 32'h0000_0000
`define VERSION_VALUE 32'h0000_0100

`define W0_PD_ALL 31
`define W0_PD_SER 29
`define W0_PD_UP 28
`define W0_PRE_N_HI 26
`define W0_PRE_N_LO 24
`define W0_SAMPLE_HI 11
`define W0_SAMPLE_LO 8
`define W1_DATA_MODE 31
`define W1_CORE_CLK 29
`define W1_PUMP_HI 23
`define W1_PUMP_LO 20
`define W1_DRIVE_HI 19
`define W1_DRIVE_LO 14
`define W1_PREEMPH_HI 13
`define W1_PREEMPH_LO 8
`define W3_UP_WIDE 23
`define W3_UP_QUAL 22
`define W3_DOWN_WIDE 21
`define W3_GEN_HI 20
`define W3_GEN_LO 19
`define W3_EXT_PHY 18
`define W3_CYCLE_HI 7
`define W3_CYCLE_LO 0

`define GEN_COUNTER 2'h2
`define GEN_TRIGGER 2'h1

`define DMA_SRC_BASE 5'h10
`define DMA_EXT_CODE 4'hA
`define DMA_REQ_BASE 8'hA0

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* inc/serial_link_pkg.sv */
// Purpose: Types shared by the link configuration block.
// Assumes: Field constants come from serial_link_map.svh.
// Notes: Carriers are packed structs.
`default_nettype none
`include "serial_link_map.svh"
package serial_link_pkg;

    typedef struct packed {
        logic pdAll;
        logic pdSer;
        logic pdUp;
        logic driverOn;
        logic [2:0] preEmphN;
        logic [3:0] samplePoint;
        logic [3:0] chargePump;
        logic [5:0] driveCurrent;
        logic [5:0] preEmphCurrent;
        logic dataMode;
        logic coreClkEn;
        logic extPhy;
    } phy_ctrl_t;

    typedef struct packed {
        logic [1:0] data;
        logic strobe;
    } up_word_t;

    // Request number that the DMA controller sees for transaction buffer k.
    function automatic logic [7:0] dma_request_number(input logic [3:0] k);
        dma_request_number = `DMA_REQ_BASE + {4'h0, k};
    endfunction : dma_request_number

endpackage : serial_link_pkg
`default_nettype wire

/* test/link_phy_model.sv */
// Purpose: External PHY model that drives the uplink sideband pins.
// Assumes: Uplink clock period 800 ns, data set up half a period before the rise.
// Notes: Released lines show the inverse of their last value, never a held copy.
`default_nettype none
module link_phy_model (
    // Uplink pins
    output logic upClk,
    output logic [1:0] upData,
    output logic upValid
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        upClk = 1'b0;
        upData = 2'h0;
        upValid = 1'b0;
    end

    // The clock stands still between words so that no stray edge is counted.
    task automatic send(input logic [1:0] d, input logic v);
        // Start a quarter period after the clk edge so no pin moves on a sampling edge.
        #25 upData = d;
        upValid = v;
        #400 upClk = 1'b1;
        #400 upClk = 1'b0;
        upData = ~d;
        upValid = ~v;
    endtask : send
endmodule : link_phy_model
`default_nettype wire

/* test/tb_top.sv */
// Purpose: Self-checking bench for the link configuration block.
// Assumes: 10 MHz clk, AXI4-Lite master tasks, PHY model on the uplink pins.
// Notes: Bus and uplink results are queued; a monitor pops them as they appear.
`default_nettype none
`include "serial_link_map.svh"
module tb_top import serial_link_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, nrst = 1'b0;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, rxDiscard, upClk, upValid;
    logic [1:0] bresp, rresp, upData;
    logic [1:0] downDataIn = 2'h0;
    logic downTrigger = 1'b0, rxValid = 1'b0;
    logic [7:0] gpioOut = 8'h00, gpioOe = 8'h00, rxIndex = 8'h00, pinOut, pinOe;
    logic [15:0] bufActive = 16'h0000, dmaReq, rxStore;
    logic [127:0] bufIndex = 128'h0;
    phy_ctrl_t phyCtrl;
    up_word_t upWord;
    wire logic [7:0] pinIn = (pinOe & pinOut) | (~pinOe & {5'h15, upData, upClk});
    int mismatches = 0, num_checks = 0;
    logic [65:0] rdq[$];
    logic [1:0] bq[$], uq[$];
    logic [15:0] offs[5] = '{`OFF_PHY_WORD0, `OFF_PHY_WORD1, `OFF_SHELL_WORD3,
        `OFF_PORT_FUNC, `OFF_VERSION};
    logic [31:0] rsts[5] = '{`RST_PHY_WORD0, `RST_PHY_WORD1, `RST_SHELL_WORD3,
        `RST_PORT_FUNC, `VERSION_VALUE};
    logic [31:0] msks[5] = '{32'hB700_0F00, 32'hA0FF_FF00, 32'h00FC_00FF, 32'h0000_FFFF,
        32'hFFFF_FFFF};

    always #50 clk = ~clk;

    serial_link_phy_config u_dut (.clk(clk), .nrst(nrst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .phyCtrl(phyCtrl), .upValidIn(upValid), .downDataIn(downDataIn),
        .downTrigger(downTrigger), .upWord(upWord), .pinIn(pinIn), .gpioOut(gpioOut),
        .gpioOe(gpioOe), .pinOut(pinOut), .pinOe(pinOe), .bufActive(bufActive),
        .bufIndex(bufIndex), .rxValid(rxValid), .rxIndex(rxIndex), .dmaReq(dmaReq),
        .rxStore(rxStore), .rxDiscard(rxDiscard));

    link_phy_model u_phy (.upClk(upClk), .upData(upData), .upValid(upValid));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_val

    task automatic tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 100) begin
            mismatches++;
            $display("ERROR %0t: handshake timeout", $time);
            give_verdict();
        end
    endtask : tick

    task automatic axi_write(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        bq.push_back(er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            tick(n);
            if (awvalid === 1'b1 && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid === 1'b1 && wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        @(posedge clk);
    endtask : axi_write

    task automatic axi_read(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e,
        input logic [1:0] er);
        int n = 0;
        rdq.push_back({er, m, e & m});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            tick(n);
            if (arvalid === 1'b1 && arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        @(posedge clk);
    endtask : axi_read

    function automatic phy_ctrl_t mk(input logic [31:0] a, input logic [31:0] b,
        input logic [31:0] c);
        mk = '{a[31], a[29], a[28], (|b[13:8]) & ~a[29] & ~a[31], a[26:24], a[11:8],
            b[23:20], b[19:14], b[13:8], b[31], b[29], c[18]};
    endfunction : mk

    // Shell word with routing bit f[0], mode md and the reset downlink cycle time 0B.
    function automatic logic [31:0] w3f(input logic [3:0] f, input logic [1:0] md);
        w3f = {8'h00, f[3:1], md, f[0], 10'h000, 8'h0B};
    endfunction : w3f

    always @(posedge clk) begin
        logic [65:0] e;
        logic [2:0] u;
        if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0)
            cmp_val({30'h0, bresp}, {30'h0, bq.pop_front()});
        if (rvalid === 1'b1 && rready === 1'b1 && rdq.size() > 0) begin
            e = rdq.pop_front();
            cmp_val(rdata & e[63:32], e[31:0]);
            cmp_val({30'h0, rresp}, {30'h0, e[65:64]});
        end
        if (upWord.strobe === 1'b1) begin
            u = (uq.size() > 0) ? {1'b1, uq.pop_front()} : 3'h0;
            cmp_val({29'h0, u[2], upWord.data}, {29'h0, 1'b1, u[1:0]});
        end
    end

    initial begin
        logic [31:0] w0, w1, v;
        logic [1:0] d;
        logic hit;
        int i, j, t;
        void'($urandom(97));
        for (i = 0; i < 16; i++) bufIndex[8*i +: 8] = 8'(3 * i + 1);
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        cmp_val(32'(phyCtrl), 32'(mk(`RST_PHY_WORD0, `RST_PHY_WORD1, 0)));
        for (i = 0; i < 5; i++)
            axi_read(offs[i], msks[i], rsts[i], `RESP_OKAY);
        for (i = 0; i < 6; i++) begin
            w0 = $urandom();
            w1 = $urandom();
            if (i < 3) w0[11:8] = 4'(2 * i);
            if (i == 0) w1[13:8] = 6'h00;
            if (i == 1) {w0[31], w0[29], w1[13:8]} = 8'h3F;
            axi_write(`OFF_PHY_WORD0, w0, `RESP_OKAY);
            axi_write(`OFF_PHY_WORD1, w1, `RESP_OKAY);
            axi_read(`OFF_PHY_WORD0, msks[0], w0, `RESP_OKAY);
            axi_read(`OFF_PHY_WORD1, msks[1], w1, `RESP_OKAY);
            cmp_val(32'(phyCtrl), 32'(mk(w0, w1, 0)));
            cmp_val(32'(phyCtrl) >> 27, 32'({w0[31], w0[29:28]}));
        end
        // A single byte lane must leave the other three lanes untouched.
        wstrb <= 4'h2;
        axi_write(`OFF_PHY_WORD1, 32'h0000_5500, `RESP_OKAY);
        wstrb <= 4'hF;
        axi_read(`OFF_PHY_WORD1, msks[1], {w1[31:16], 8'h55, w1[7:0]}, `RESP_OKAY);
        axi_write(`OFF_VERSION, 32'hFFFF_FFFF, `RESP_OKAY);
        axi_read(`OFF_VERSION, 32'hFFFF_FFFF, `VERSION_VALUE, `RESP_OKAY);
        axi_write(16'h7308, 32'hFFFF_FFFF, `RESP_SLVERR);
        axi_read(16'h7308, 32'hFFFF_FFFF, 32'h0, `RESP_SLVERR);
        axi_write(`OFF_SHELL_WORD3, w3f(4'hB, 2'h0), `RESP_OKAY);
        cmp_val({31'h0, phyCtrl.extPhy}, 32'h1);
        // Only both function bits together may hand a pin to the link.
        for (i = 0; i < 3; i++) begin
            axi_write(`OFF_PORT_FUNC, 32'(16'h00FF << (4 * i)), `RESP_OKAY);
            v = $urandom();
            gpioOut <= v[7:0];
            gpioOe <= v[15:8];
            repeat (3) @(posedge clk);
            cmp_val({16'h0, pinOe, pinOut}, {16'h0, v[15:0]});
        end
        axi_write(`OFF_PORT_FUNC, 32'h0000_FFFF, `RESP_OKAY);
        cmp_val({29'h0, pinOe[2:0]}, 32'h0);
        for (j = 0; j < 5; j++) begin
            axi_write(`OFF_SHELL_WORD3, w3f({j[0], j[1], 1'b1, j < 4}, 2'h0), `RESP_OKAY);
            for (i = 0; i < 4; i++) begin
                v = $urandom();
                d = v[1:0];
                if (j < 4 && (j[1] ? d[1] : v[2])) uq.push_back(j[0] ? d : {1'b0, d[0]});
                u_phy.send(d, v[2]);
                repeat (4) @(posedge clk);
            end
        end
        axi_write(`OFF_SHELL_WORD3, w3f(4'h3, 2'h1), `RESP_OKAY);
        for (i = 0; i < 4; i++) begin
            v[0] = pinOut[6];
            downTrigger <= 1'b1;
            @(posedge clk);
            downTrigger <= 1'b0;
            repeat (3) @(posedge clk);
            cmp_val({30'h0, pinOe[6], pinOut[6]}, {30'h0, 1'b1, ~v[0]});
        end
        axi_write(`OFF_SHELL_WORD3, w3f(4'h3, 2'h2), `RESP_OKAY);
        t = 0;
        for (i = 0; i < 50; i++) begin
            v[0] = pinOut[6];
            @(posedge clk);
            if (pinOut[6] !== v[0]) t++;
        end
        cmp_val(32'(t >= 9 && t <= 11), 32'h1);
        downDataIn <= 2'h3;
        for (j = 0; j < 4; j++) begin
            axi_write(`OFF_SHELL_WORD3, w3f({2'h0, j[0], 1'b1}, {2{j[1]}}), `RESP_OKAY);
            repeat (3) @(posedge clk);
            cmp_val({29'h0, pinOut[7:5]}, {29'h0, 1'b0, j[0], 1'b1});
        end
        for (i = 0; i < 8; i++) begin
            v = $urandom();
            t = v[19:16];
            if (i[0]) v[t] = 1'b1;
            hit = (i != 7) && v[t];
            bufActive <= v[15:0];
            rxIndex <= (i == 7) ? 8'hC8 : 8'(3 * t + 1);
            rxValid <= 1'b1;
            @(posedge clk);
            rxValid <= 1'b0;
            @(negedge clk);
            cmp_val({15'h0, rxDiscard, rxStore}, {15'h0, !hit, hit ? 16'(1 << t) : 16'h0});
            cmp_val({16'h0, dmaReq}, {16'h0, v[15:0]});
            cmp_val({24'h0, dma_request_number(4'(t))}, 32'h0000_00A0 + 32'(t));
            @(posedge clk);
        end
        // Reset again mid-run: every word must fall back to its default.
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 5; i++)
            axi_read(offs[i], msks[i], rsts[i], `RESP_OKAY);
        cmp_val(32'(phyCtrl), 32'(mk(`RST_PHY_WORD0, `RST_PHY_WORD1, 0)));
        cmp_val(32'(bq.size() + rdq.size() + uq.size()), 32'h0);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
